// file: shared/lcp_pkg.sv
package lcp_pkg;

    // Configuration word offsets
    localparam logic [7:0] CLAMP_LIMITS_OFFSET      = 8'h08;
    localparam logic [7:0] LINEARIZE_CONTROL_OFFSET = 8'h12;
    localparam logic [7:0] POST_TRIM_OFFSET         = 8'h13;
    localparam logic [7:0] OUTPUT_CONFIG_OFFSET     = 8'h14;

    // Word widths and table counts
    localparam int SAMPLE_W    = 16;
    localparam int CLAMP_W     = 24;
    localparam int LINCTL_W    = 26;
    localparam int POSTTRIM_W  = 24;
    localparam int OUTCFG_W    = 7;
    localparam int ENTRY_W     = 13;
    localparam int ENTRY_COUNT = 17;
    localparam int BIN_COUNT   = 8;

    // Linearize control fields
    localparam int TABLE_EN_BIT   = 13;
    localparam int BIN_EN_BIT     = 14;
    localparam int INV_OUT_BIT    = 15;
    localparam int INV_IN_BIT     = 16;
    localparam int HYST_LSB       = 17;
    localparam int HYST_W         = 8;
    localparam int SCALAR_BIT     = 25;

    // Post trim and clamp fields
    localparam int GAIN_LSB       = 0;
    localparam int OFFSET_LSB     = 12;
    localparam int TRIM_FIELD_W   = 12;
    localparam int UPPER_LSB      = 0;
    localparam int LOWER_LSB      = 12;
    localparam int GAIN_FRAC_BITS = 11;

    // Output configuration fields
    localparam int PROTO_LSB = 0;
    localparam int PROTO_W   = 3;
    localparam int RATE_LSB  = 3;
    localparam int RATE_W    = 4;
    localparam logic [2:0] PROTO_PWM = 3'h0;

    // Arithmetic constants
    localparam logic signed [23:0] LOC_MIDPOINT  = 24'sh001000;
    localparam logic signed [15:0] BIN_FLOOR     = 16'sh8000;
    localparam logic        [3:0]  UPPER_FILL    = 4'hF;
    localparam logic        [3:0]  LOWER_FILL    = 4'h0;

    // Buffering and PWM defaults
    localparam int FIFO_DEPTH   = 16;
    localparam int PWM_MIN_LOG2 = 8;
    localparam logic [4:0] PWM_MAX_LOG2 = 5'h10;

endpackage : lcp_pkg

// file: shared/stream_if.sv
interface stream_if #(
    parameter int WIDTH = 16
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : stream_if

// file: logic/sample_fifo.sv
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Streams
    stream_if.sink   inPort,
    stream_if.source outPort
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 count;
        logic                        notFull;
        logic                        notEmpty;
    } fifo_state_type;

    fifo_state_type cur;
    fifo_state_type next_cur;
    logic           push;
    logic           pop;

    assign push            = inPort.valid && cur.notFull;
    assign pop             = outPort.ready && cur.notEmpty;
    assign inPort.ready    = cur.notFull;
    assign outPort.valid   = cur.notEmpty;
    assign outPort.data    = cur.mem[cur.rd];

    always_comb begin
        next_cur = cur;
        if (push) begin
            next_cur.mem[cur.wr] = inPort.data;
            next_cur.wr          = cur.wr + 1'b1;
        end
        if (pop) begin
            next_cur.rd = cur.rd + 1'b1;
        end
        if (push && !pop) begin
            next_cur.count = cur.count + 1'b1;
        end else if (pop && !push) begin
            next_cur.count = cur.count - 1'b1;
        end
        next_cur.notFull  = next_cur.count != (AW+1)'(DEPTH);
        next_cur.notEmpty = next_cur.count != '0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.notFull  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

endmodule : sample_fifo

// file: logic/linearize_clamp_pwm_path.sv
// Functional notes
// - Bin mode outputs a discrete level per bin bounded by programmed locations.
// - Hysteresis applies only while input decreases; rising input uses zero.
// - Threshold is 8*(loc-4096) minus twice hysteresis; below first gives -32768, or level entry 8 when location 0 is zero.
// - Control bit 13 enables the linearization table.
// - Control bit 14 selects binning instead of interpolation.
// - Control bit 15 inverts the linearization result.
// - Control bit 16 inverts the value entering linearization.
// - Hysteresis comes from control bits 24:17, in output LSBs.
// - Control bit 25 doubles interpolation coefficients and bin levels before use.
// - Post trim is value times one plus gain, plus offset, 16-bit signed.
// - Gain trim is bits 11:0, step 2^-11, span -1 to +1 minus 2^-11.
// - Offset trim is bits 23:12, step 16, span -32768 to +32752.
// - Add 32768 to make unsigned before both clamp comparisons.
// - Above upper limit outputs upper limit; this check wins.
// - Below lower limit outputs lower limit; otherwise pass value unchanged.
// - Upper limit is clamp bits 11:0, step 16, span 15 to 65535.
// - Lower limit is clamp bits 23:12, step 16, span 0 to 65520.
// - Output pin is suppressed while serial programming uses it.
// - PWM is constant frequency with high time proportional to the clamped value.
// - Protocol field bits 2:0 equal zero selects PWM.
// - Rate field bits 6:3 sets the PWM carrier frequency.
// - Interpolating mode is piecewise linear over 16 segments.
// - In bin mode the first eight entries are locations, the next eight (8 to 15) levels, 13 bits each; entry 16 is unused.
module linearize_clamp_pwm_path #(
    parameter int FIFO_DEPTH   = lcp_pkg::FIFO_DEPTH,
    parameter int PWM_MIN_LOG2 = lcp_pkg::PWM_MIN_LOG2
) (
    // Clock and reset
    input  wire logic                                            mclk,
    input  wire logic                                            rst_n,
    // Compensated sample stream
    input  wire logic                                            sampleValid,
    input  wire logic [lcp_pkg::SAMPLE_W-1:0]                    sampleData,
    output wire logic                                            sampleReady,
    // Configuration words
    input  wire logic [lcp_pkg::CLAMP_W-1:0]                     clampLimits,
    input  wire logic [lcp_pkg::LINCTL_W-1:0]                    linearizeControl,
    input  wire logic [lcp_pkg::POSTTRIM_W-1:0]                  postTrim,
    input  wire logic [lcp_pkg::OUTCFG_W-1:0]                    outputConfig,
    input  wire logic [lcp_pkg::ENTRY_COUNT*lcp_pkg::ENTRY_W-1:0] tableEntries,
    // Serial programming owns the pin
    input  wire logic                                            programmingActive,
    // Open-drain output pin
    output wire logic                                            outPinOut,
    output wire logic                                            outPinOe,
    // Status
    output wire logic [lcp_pkg::SAMPLE_W-1:0]                    clampedValue,
    output wire logic                                            pwmRunning
);
    import lcp_pkg::*;

    typedef enum logic [1:0] {
        PWM_SUPPRESSED = 2'b01,
        PWM_RUN        = 2'b10
    } pwm_state_type;

    typedef struct packed {
        pwm_state_type        state;
        logic [15:0]          cnt;
        logic [15:0]          clamped;
        logic signed [15:0]   prevIn;
        logic                 havePrev;
        logic                 oe;
        logic                 pinOut;
    } top_state_type;

    top_state_type cur;
    top_state_type next_cur;

    stream_if #(.WIDTH(SAMPLE_W)) inIf ();
    stream_if #(.WIDTH(SAMPLE_W)) outIf ();

    assign inIf.valid = sampleValid;
    assign inIf.data  = sampleData;
    assign sampleReady = inIf.ready;

    sample_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) sampleFifo (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .inPort  (inIf.sink),
        .outPort (outIf.source)
    );

    // Coefficient for interpolation, delta output times four
    function automatic logic signed [23:0] lineCoef(input logic [4:0] idx, input logic scal);
        logic signed [23:0] v;
        v = 24'($signed(tableEntries[ENTRY_W*int'(idx) +: ENTRY_W])) <<< 2;
        if (scal) begin
            v = v <<< 1;
        end
        return v;
    endfunction : lineCoef

    // Trim and level sums can leave 16 bits; saturate rather than wrap
    function automatic logic signed [15:0] sat16(input logic signed [23:0] v);
        if (v > 24'sh007FFF) begin
            return 16'sh7FFF;
        end else if (v < -24'sh008000) begin
            return 16'sh8000;
        end
        return v[15:0];
    endfunction : sat16

    // Bin output level, offset binary entry scaled to signed output
    function automatic logic signed [15:0] levelAt(input int idx, input logic scal);
        logic signed [23:0] v;
        v = ($signed({11'h000, tableEntries[ENTRY_W*idx +: ENTRY_W]}) - LOC_MIDPOINT) <<< 3;
        if (scal) begin
            v = v <<< 1;
        end
        return sat16(v);
    endfunction : levelAt

    logic signed [15:0] yRaw;
    logic signed [15:0] yIn;
    logic               linEnable;
    logic               binEnable;
    logic               scal;
    logic [3:0]         seg;
    logic [11:0]        frac;
    logic signed [23:0] kLo;
    logic signed [23:0] kHi;
    logic signed [39:0] prodStep;
    logic signed [15:0] interpY;
    logic               decreasing;
    logic [9:0]         hystUsed;
    logic signed [23:0] thr [BIN_COUNT];
    logic signed [15:0] binLevel;
    logic signed [15:0] y3pre;
    logic signed [15:0] y3;
    logic signed [27:0] prodGain;
    logic signed [23:0] offsetFull;
    logic signed [15:0] y4;
    logic [15:0]        clampIn;
    logic [15:0]        upper;
    logic [15:0]        lower;
    logic [15:0]        clampOut;

    always_comb begin
        yRaw      = $signed(outIf.data);
        linEnable = linearizeControl[TABLE_EN_BIT];
        binEnable = linearizeControl[BIN_EN_BIT];
        scal      = linearizeControl[SCALAR_BIT];
        yIn       = linearizeControl[INV_IN_BIT] ? ~yRaw : yRaw;

        // Seventeen evenly spaced points across the signed input span
        seg      = {~yIn[15], yIn[14:12]};
        frac     = yIn[11:0];
        kLo      = lineCoef({1'b0, seg}, scal);
        kHi      = lineCoef({1'b0, seg} + 5'h01, scal);
        prodStep = 40'(kHi - kLo) * $signed({28'h0000000, frac});
        interpY  = sat16(24'(yIn) + kLo + 24'(prodStep >>> 12));

        // Direction is judged against the last sample taken, after input inversion
        decreasing = cur.havePrev && (yIn < cur.prevIn);
        hystUsed   = decreasing ?
            {1'b0, linearizeControl[HYST_LSB +: HYST_W], 1'b0} : 10'h000;
        for (int x = 0; x < BIN_COUNT; x++) begin
            thr[x] = (($signed({11'h000, tableEntries[ENTRY_W*x +: ENTRY_W]}) - LOC_MIDPOINT)
                     <<< 3) - $signed({14'h0000, hystUsed});
        end
        // Locations sit in the lower half, levels in the upper half
        binLevel = (tableEntries[ENTRY_W-1:0] != 13'h0000) ?
            BIN_FLOOR : levelAt(BIN_COUNT, scal);
        for (int x = 0; x < BIN_COUNT; x++) begin
            if (24'(yIn) > thr[x]) begin
                binLevel = levelAt(BIN_COUNT + x, scal);
            end
        end

        y3pre = binEnable ? binLevel : interpY;
        y3    = linearizeControl[INV_OUT_BIT] ? ~y3pre : y3pre;
        if (!linEnable) begin
            y3 = yRaw;
        end

        prodGain   = 28'(y3) * 28'($signed(postTrim[GAIN_LSB +: TRIM_FIELD_W]));
        offsetFull = 24'($signed({postTrim[OFFSET_LSB +: TRIM_FIELD_W], 4'h0}));
        y4         = sat16(24'(y3) + 24'(prodGain >>> GAIN_FRAC_BITS) + offsetFull);

        clampIn = {~y4[15], y4[14:0]};
        upper   = {clampLimits[UPPER_LSB +: TRIM_FIELD_W], UPPER_FILL};
        lower   = {clampLimits[LOWER_LSB +: TRIM_FIELD_W], LOWER_FILL};
        // Upper check first, so it wins if the limits are ever crossed
        if (clampIn > upper) begin
            clampOut = upper;
        end else if (clampIn < lower) begin
            clampOut = lower;
        end else begin
            clampOut = clampIn;
        end
    end

    logic [4:0]  periodLog2;
    logic [4:0]  shiftDown;
    logic [15:0] periodMask;
    logic [15:0] highCount;
    logic        wrap;
    logic        pop;
    logic        runReq;

    always_comb begin
        periodLog2 = 5'(PWM_MIN_LOG2) + {1'b0, outputConfig[RATE_LSB +: RATE_W]};
        if (periodLog2 > PWM_MAX_LOG2) begin
            periodLog2 = PWM_MAX_LOG2;
        end
        shiftDown  = PWM_MAX_LOG2 - periodLog2;
        periodMask = 16'hFFFF >> shiftDown;
        highCount  = cur.clamped >> shiftDown;
        // A rate change can leave the counter past the new end: restart at once
        wrap       = cur.cnt >= periodMask;
        pop        = wrap && outIf.valid;
        runReq     = (outputConfig[PROTO_LSB +: PROTO_W] == PROTO_PWM)
                     && !programmingActive;
    end

    // New samples are taken only at a period boundary, so the FIFO backs up
    assign outIf.ready = wrap;

    always_comb begin
        next_cur        = cur;
        next_cur.cnt    = wrap ? 16'h0000 : cur.cnt + 16'h0001;
        next_cur.state  = runReq ? PWM_RUN : PWM_SUPPRESSED;
        // Pin released for the high part, pulled low for the rest
        next_cur.oe     = runReq && (cur.cnt >= highCount);
        next_cur.pinOut = 1'b0;
        if (pop) begin
            next_cur.clamped  = clampOut;
            next_cur.prevIn   = yIn;
            next_cur.havePrev = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur       <= '0;
            cur.state <= PWM_SUPPRESSED;
        end else begin
            cur <= next_cur;
        end
    end

    assign outPinOut    = cur.pinOut;
    assign outPinOe     = cur.oe;
    assign clampedValue = cur.clamped;
    // One-hot run bit, so the flag comes straight from its flip-flop
    assign pwmRunning   = cur.state[1];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence seqPopAbove;
        pop && (clampIn > upper);
    endsequence

    sequence seqPopBelow;
        pop && (clampIn <= upper) && (clampIn < lower);
    endsequence

    sequence seqZeroDutyRun;
        (cur.state == PWM_RUN) && runReq && (highCount == 16'h0000) && (cur.cnt == 16'h0000);
    endsequence

    sequence seqBypassPop;
        pop && !linEnable && (postTrim == 24'h000000) && (clampLimits == 24'h000FFF);
    endsequence

    sequence seqOffsetPop;
        pop && !linEnable && (yRaw == 16'sh0000) && (clampLimits == 24'h000FFF)
        && (postTrim[GAIN_LSB +: TRIM_FIELD_W] == 12'h000);
    endsequence

    sequence seqGainPop;
        pop && !linEnable && (yRaw == 16'sh1000) && (clampLimits == 24'h000FFF)
        && (postTrim[OFFSET_LSB +: TRIM_FIELD_W] == 12'h000);
    endsequence

    sequence seqPeriodWrap;
        wrap && runReq;
    endsequence

    sequence seqDutyStarts;
        runReq && (highCount != 16'h0000);
    endsequence

    clamp_upper_a: assert property (seqPopAbove |=> clampedValue == $past(upper))
        else $error("upper clamp not applied");
    clamp_lower_a: assert property (seqPopBelow |=> clampedValue == $past(lower))
        else $error("lower clamp not applied");
    clamp_pass_a: assert property (pop && clampIn <= upper && clampIn >= lower
        |=> clampedValue == 16'($past(y4) + 16'sh8000))
        else $error("unclamped value not offset by half scale");
    suppress_pin_a: assert property (programmingActive |=> !outPinOe && !pwmRunning)
        else $error("pin driven during programming");
    protocol_sel_a: assert property (outputConfig[2:0] != 3'h0 |=> !outPinOe)
        else $error("pin driven outside pwm protocol");
    table_bypass_a: assert property (seqBypassPop
        |=> clampedValue == ($past(yRaw) ^ 16'h8000))
        else $error("table applied while disabled");
    rising_hyst_a: assert property (cur.havePrev && yIn >= cur.prevIn |-> hystUsed == 10'h000)
        else $error("hysteresis used on rising input");
    bin_floor_a: assert property (binEnable && tableEntries[12:0] != 13'h0000
        && 24'(yIn) <= thr[0] |-> binLevel == BIN_FLOOR)
        else $error("bin floor level wrong");
    zero_duty_a: assert property (seqZeroDutyRun ##1 runReq |=> outPinOe)
        else $error("zero duty did not hold pin low");
    period_pop_a: assert property (pop |=> cur.cnt == 16'h0000 && cur.havePrev)
        else $error("sample not taken at period boundary");

    // Trim and clamp path, seen at the registered result; top bin level seen at the unregistered binLevel
    offset_step_a: assert property (seqOffsetPop
        |=> clampedValue == 16'h8000 + {$past(postTrim[OFFSET_LSB +: TRIM_FIELD_W]), 4'h0})
        else $error("offset trim step wrong");
    gain_step_a: assert property (seqGainPop
        |=> clampedValue
            == 16'h9000 + (16'($signed($past(postTrim[GAIN_LSB +: TRIM_FIELD_W]))) << 1))
        else $error("gain trim step wrong");
    clamp_range_a: assert property (pop && (lower <= upper)
        |=> clampedValue <= $past(upper) && clampedValue >= $past(lower))
        else $error("clamped value outside limits");
    sample_hold_a: assert property (!pop |=> $stable(clampedValue))
        else $error("clamped value changed without a sample");
    bin_top_a: assert property (binEnable && 24'(yIn) > thr[BIN_COUNT-1]
        |-> binLevel == levelAt(2 * BIN_COUNT - 1, scal))
        else $error("top bin level wrong");

    // Pin, counter and run flag
    period_start_a: assert property (seqPeriodWrap ##1 seqDutyStarts |=> !outPinOe)
        else $error("pin not released at period start");
    rate_change_a: assert property (cur.cnt > periodMask |=> cur.cnt == 16'h0000)
        else $error("counter not restarted after rate change");
    run_flag_a: assert property (runReq |=> pwmRunning)
        else $error("pwm not reported running");
    stop_flag_a: assert property (!runReq |=> !pwmRunning)
        else $error("pwm reported running while suppressed");

endmodule : linearize_clamp_pwm_path

// file: dv/pwm_reader.sv
module pwm_reader (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Pin as seen through the pull-up
    input  wire logic        pinLevel,
    // Last complete period
    output logic      [16:0] highLen,
    output logic      [16:0] periodLen
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        prevLevel;
    logic [16:0] runLen;
    logic [16:0] hiLen;

    // A period is measured from one rising pin edge to the next
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prevLevel <= 1'b1;
            runLen    <= 17'h00000;
            hiLen     <= 17'h00000;
            highLen   <= 17'h00000;
            periodLen <= 17'h00000;
        end else begin
            prevLevel <= pinLevel;
            if (pinLevel && !prevLevel) begin
                periodLen <= runLen;
                highLen   <= hiLen;
                runLen    <= 17'h00001;
                hiLen     <= 17'h00001;
            end else begin
                runLen <= runLen + 17'h00001;
                hiLen  <= hiLen + {16'h0000, pinLevel};
            end
        end
    end
endmodule : pwm_reader

// file: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcp_pkg::*;

    logic                        mclk              = 1'b0;
    logic                        rst_n             = 1'b0;
    logic                        sampleValid       = 1'b0;
    logic [SAMPLE_W-1:0]         sampleData        = 16'h0000;
    logic [CLAMP_W-1:0]          clampLimits       = 24'h000FFF;
    logic [LINCTL_W-1:0]         linearizeControl  = 26'h0000000;
    logic [POSTTRIM_W-1:0]       postTrim          = 24'h000000;
    logic [OUTCFG_W-1:0]         outputConfig      = 7'h00;
    logic [ENTRY_COUNT*ENTRY_W-1:0] tableEntries   = '0;
    logic                        programmingActive = 1'b0;
    wire logic                   sampleReady;
    wire logic                   outPinOut;
    wire logic                   outPinOe;
    wire logic                   pwmRunning;
    wire logic                   pinLevel;
    wire logic [SAMPLE_W-1:0]    clampedValue;
    wire logic [16:0]            highLen;
    wire logic [16:0]            periodLen;
    int                          fails = 0;
    int                          checks_done = 0;
    int                          n;
    int                          k;

    // Open-drain pin with a pull-up
    assign pinLevel = outPinOe ? outPinOut : 1'b1;

    always #4 mclk = ~mclk;

    linearize_clamp_pwm_path #(.FIFO_DEPTH(16), .PWM_MIN_LOG2(4)) dut (
        .mclk(mclk), .rst_n(rst_n), .sampleValid(sampleValid), .sampleData(sampleData),
        .sampleReady(sampleReady), .clampLimits(clampLimits),
        .linearizeControl(linearizeControl), .postTrim(postTrim),
        .outputConfig(outputConfig), .tableEntries(tableEntries),
        .programmingActive(programmingActive), .outPinOut(outPinOut), .outPinOe(outPinOe),
        .clampedValue(clampedValue), .pwmRunning(pwmRunning));

    pwm_reader partner (
        .mclk(mclk), .rst_n(rst_n), .pinLevel(pinLevel),
        .highLen(highLen), .periodLen(periodLen));

    task automatic end_sim();
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic cycles(input int c);
        repeat (c) @(posedge mclk);
    endtask : cycles

    // Offer one sample and hold it until the edge that takes it
    task automatic push(input logic [15:0] s);
        int w;
        w = 0;
        sampleValid <= 1'b1;
        sampleData  <= s;
        @(posedge mclk);
        while (sampleReady !== 1'b1 && w < 5000) begin
            w++;
            @(posedge mclk);
        end
        if (w >= 5000) begin
            fails++;
            end_sim();
        end
        sampleValid <= 1'b0;
    endtask : push

    task automatic run(input logic [15:0] s, input logic [15:0] exp, input string name);
        push(s);
        cycles(40);
        chk(name, {16'h0000, exp}, {16'h0000, clampedValue});
    endtask : run

    // Pin must stay released and PWM reported stopped
    task automatic quiet(input string name);
        int bad;
        bad = 0;
        cycles(2);
        repeat (70) begin
            @(posedge mclk);
            if (outPinOe !== 1'b0 || pwmRunning !== 1'b0) bad++;
        end
        chk(name, 0, bad);
    endtask : quiet

    initial begin
        cycles(8);
        rst_n <= 1'b1;
        cycles(1);
        chk("oe reset", 0, {31'h0, outPinOe});
        chk("ready reset", 1, {31'h0, sampleReady});
        chk("value reset", 0, {16'h0000, clampedValue});
        for (int i = 0; i < 17; i++) tableEntries[13*i +: 13] <= 13'h0010;
        run(16'h0000, 16'h8000, "table off");
        postTrim <= 24'h000400;
        run(16'h1000, 16'h9800, "gain trim");
        postTrim <= 24'hFFF000;
        run(16'h0000, 16'h7FF0, "offset trim");
        postTrim    <= 24'h000000;
        clampLimits <= 24'h000900;
        run(16'h7000, 16'h900F, "upper clamp");
        clampLimits <= 24'h100FFF;
        run(16'h8000, 16'h1000, "lower clamp");
        clampLimits <= 24'h000FFF;
        linearizeControl <= 26'h0002000;
        run(16'h0000, 16'h8040, "interpolate");
        linearizeControl <= 26'h2002000;
        run(16'h0000, 16'h8080, "interp doubled");
        for (int i = 0; i < 8; i++) begin
            tableEntries[13*i +: 13]     <= 13'h1000 + 13'(i * 512);
            tableEntries[13*(i+8) +: 13] <= 13'h1000 + 13'(i * 256);
        end
        linearizeControl <= 26'h1006000;
        run(16'd5000, 16'h8800, "bin one");
        run(16'd9000, 16'h9000, "bin rising");
        run(16'd8000, 16'h9000, "bin hysteresis");
        run(16'd8000, 16'h8800, "bin level");
        run(-16'sd1000, 16'h0000, "bin floor");
        run(16'd30000, 16'hB800, "bin top");
        linearizeControl <= 26'h2006000;
        run(16'd9000, 16'hA000, "bin doubled");
        linearizeControl <= 26'h000E000;
        run(16'd9000, 16'h6FFF, "invert out");
        linearizeControl <= 26'h0016000;
        run(16'hEC77, 16'h8800, "invert in");
        linearizeControl <= 26'h0000000;
        outputConfig     <= 7'h20;
        n = 0;
        k = 0;
        sampleValid <= 1'b1;
        sampleData  <= 16'h0000;
        while (k < 20) begin
            @(posedge mclk);
            k++;
            if (sampleReady !== 1'b1) break;
            n++;
            sampleData <= 16'(n * 256);
        end
        sampleValid <= 1'b0;
        chk("fifo fill", 1, {31'h0, n >= 16 && n <= 17});
        cycles(4700);
        chk("fifo drain", 1, {31'h0, sampleReady});
        chk("fifo last", 32'h8000 + (n - 1) * 256, {16'h0000, clampedValue});
        outputConfig <= 7'h00;
        run(16'h0000, 16'h8000, "pwm value");
        cycles(48);
        chk("pwm period", 16, {15'h0, periodLen});
        chk("pwm high", 8, {15'h0, highLen});
        chk("pwm running", 1, {31'h0, pwmRunning});
        outputConfig <= 7'h10;
        cycles(200);
        chk("rate period", 64, {15'h0, periodLen});
        chk("rate high", 32, {15'h0, highLen});
        outputConfig <= 7'h01;
        quiet("other protocol");
        outputConfig      <= 7'h00;
        programmingActive <= 1'b1;
        quiet("programming");
        end_sim();
    end
endmodule : tb
